// ---- encoder_speed_supervisor.sv ----
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module encoder_speed_supervisor
    import ess_pkg::*;
#(
    parameter int unsigned  TENTH_CYC   = int'(TENTH_CYCLES),
    parameter int unsigned  WIN_CYC     = int'(WINDOW_CYCLES),
    parameter logic [15:0]  MAX_RPM_RST = 16'h0708,
    parameter logic [15:0]  EDECEL_RST  = 16'h0064
) (
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic               enc_a,
    input  wire logic               enc_b,
    input  wire logic signed [15:0] speed_ref,
    input  wire logic               run_cmd,
    input  wire logic               ramping,
    input  wire logic               torque_mode,
    input  wire logic [15:0]        active_decel_time,
    input  wire logic [AW-1:0]      reg_addr,
    input  wire logic [DW-1:0]      reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [DW-1:0]           reg_rdata,
    output logic signed [15:0]      speed_rpm,
    output logic                    speed_valid,
    output logic                    pulse_monitor,
    output logic                    integ_enable,
    output logic                    fault_out,
    output logic                    alarm_out,
    output logic                    stop_ramp,
    output logic                    stop_coast,
    output logic                    stop_fast,
    output logic [15:0]             decel_time
);
    // ==============================================
    // constants and helpers
    localparam longint RPM_SCALE = SEC_PER_MIN * SEC_NS
                                 / (EDGES_PER_PULSE * longint'(WIN_CYC) * CLK_NS);

    function automatic logic [15:0] clampv(input logic [15:0] v, input logic [15:0] mx);
        clampv = (v > mx) ? mx : v;
    endfunction : clampv

    function automatic logic [15:0] absv(input logic signed [16:0] v);
        logic [16:0] m;
        m = v[16] ? 17'(-v) : 17'(v);
        absv = m[16] ? 16'hffff : m[15:0];
    endfunction : absv

    typedef struct packed {
        logic [15:0]        pulses_per_rev;
        logic [15:0]        cfg;
        logic [15:0]        monitor_divider;
        logic [15:0]        overspeed_level;
        logic [15:0]        overspeed_delay;
        logic [15:0]        deviation_level;
        logic [15:0]        deviation_delay;
        logic [15:0]        gear_teeth_one;
        logic [15:0]        gear_teeth_two;
        logic [15:0]        loss_detect_time;
        logic [15:0]        max_output_frequency;
        logic [15:0]        emergency_decel_time;
        logic               delay_written;
        logic [1:0]         ab;
        logic               mon_out;
        logic [5:0]         mon_acc;
        logic signed [19:0] edges;
        logic [31:0]        win_cnt;
        logic [2:0][23:0]   sub;
        logic [2:0][7:0]    tenths;
        logic [2:0]         hit;
        div_e               st;
        logic [5:0]         step_cnt;
        logic [47:0]        quo;
        logic [47:0]        rem;
        logic [47:0]        den;
        logic               neg;
        logic signed [15:0] speed;
        logic               spd_valid;
        logic [15:0]        rdata;
        logic [15:0]        decel;
    } state_s;

    state_s      s;
    state_s      n;
    logic        edge_evt;
    logic        win_end;
    logic        gear_on;
    logic        over_cond;
    logic        dvtn_cond;
    logic [2:0]  act;
    logic [2:0]  det;
    logic [2:0]  flt;
    logic [1:0]  react [3];
    logic        mon_n;
    logic [5:0]  mon_m;
    logic        coast_any;
    logic        fast_any;
    logic        ramp_any;

    // ==============================================
    // next state
    always_comb begin : next_state
        logic [1:0]  g_prev;
        logic [1:0]  g_cur;
        logic [1:0]  step;
        logic        inc;
        logic        dec;
        logic        dir;
        logic [19:0] mag;
        logic [48:0] rsh;
        logic [15:0] raw_m;
        logic [6:0]  sum;
        logic [15:0] spd_mag;
        logic [15:0] err_mag;
        logic [2:0]  clr;
        logic [1:0]  new_meth;
        n        = s;
        g_prev   = {s.ab[1], ^s.ab};
        g_cur    = {enc_a, enc_a ^ enc_b};
        step     = g_cur - g_prev;
        dir      = s.cfg[CFG_DIR];
        inc      = (step == 2'h3 && !dir) || (step == 2'h1 && dir);
        dec      = (step == 2'h1 && !dir) || (step == 2'h3 && dir);
        edge_evt = {enc_a, enc_b} != s.ab;
        win_end  = s.win_cnt == 32'(WIN_CYC - 1);
        mag      = '0;
        rsh      = '0;
        sum      = '0;
        clr      = '0;
        new_meth = '0;
        raw_m    = '0;
        spd_mag  = '0;
        err_mag  = '0;
        n.ab     = {enc_a, enc_b};
        n.spd_valid = 1'b0;

        // signed edge count per window, then one long division
        n.win_cnt = win_end ? 32'h0 : s.win_cnt + 32'h1;
        if (win_end) begin
            n.edges = inc ? 20'sh1 : (dec ? -20'sh1 : 20'sh0);
        end else begin
            n.edges = s.edges + (inc ? 20'sh1 : (dec ? -20'sh1 : 20'sh0));
        end
        // zero teeth or flux vector falls back to a unity ratio
        gear_on = s.gear_teeth_one != 16'h0 && s.gear_teeth_two != 16'h0
                  && s.cfg[CFG_METHOD +: 2] != METHOD_FLUX;
        unique case (s.st)
            ST_IDLE: begin
                if (win_end) begin
                    n.neg      = s.edges[19];
                    mag        = s.edges[19] ? 20'(-s.edges) : 20'(s.edges);
                    n.quo      = 48'(mag) * 48'(RPM_SCALE)
                                 * (gear_on ? 48'(s.gear_teeth_two) : 48'h1);
                    n.den      = 48'(s.pulses_per_rev)
                                 * (gear_on ? 48'(s.gear_teeth_one) : 48'h1);
                    n.rem      = '0;
                    n.step_cnt = '0;
                    if (s.pulses_per_rev == 16'h0) begin
                        n.speed     = '0;
                        n.spd_valid = 1'b1;
                    end else begin
                        n.st = ST_DIV;
                    end
                end
            end
            ST_DIV: begin
                rsh        = {s.rem, s.quo[47]};
                n.quo      = {s.quo[46:0], 1'b0};
                if (rsh >= {1'b0, s.den}) begin
                    n.rem    = 48'(rsh - {1'b0, s.den});
                    n.quo[0] = 1'b1;
                end else begin
                    n.rem = rsh[47:0];
                end
                n.step_cnt = s.step_cnt + 6'h1;
                if (s.step_cnt == 6'(DIV_STEPS - 1)) begin
                    // saturate rather than wrap on absurd settings
                    n.speed     = (n.quo > 48'h7fff) ? 16'sh7fff : 16'(n.quo);
                    n.speed     = s.neg ? -n.speed : n.speed;
                    n.spd_valid = 1'b1;
                    n.st        = ST_IDLE;
                end
            end
        endcase

        // pulse monitor, toggles so both A edges keep the ratio
        mon_n = s.monitor_divider >= MON_N_STEP;
        raw_m = s.monitor_divider - (mon_n ? MON_N_STEP : 16'h0);
        raw_m = clampv(raw_m, MON_M_MAX);
        mon_m = (raw_m < 16'(mon_n) + 16'h1) ? 6'(mon_n) + 6'h1 : raw_m[5:0];
        if (enc_a != s.ab[1]) begin
            sum = 7'(s.mon_acc) + 7'(mon_n) + 7'h1;
            if (sum >= 7'(mon_m)) begin
                n.mon_acc = 6'(sum - 7'(mon_m));
                n.mon_out = !s.mon_out;
            end else begin
                n.mon_acc = sum[5:0];
            end
        end

        // fault detection with delay in tenths of a second
        spd_mag   = absv(17'(s.speed));
        err_mag   = absv(17'(speed_ref) - 17'(s.speed));
        over_cond = 32'(spd_mag) * PCT
                    > 32'(s.overspeed_level) * 32'(s.max_output_frequency);
        dvtn_cond = 32'(err_mag) * PCT
                    > 32'(s.deviation_level) * 32'(s.max_output_frequency)
                    && !ramping && !torque_mode;
        // a locked shaft under command stops edges just like a broken wire
        act[F_LOSS] = run_cmd && !edge_evt;
        act[F_OVER] = over_cond;
        act[F_DVTN] = dvtn_cond;
        for (int i = 0; i < 3; i++) begin
            det[i] = 1'b0;
            if (!act[i]) begin
                n.sub[i]    = '0;
                n.tenths[i] = '0;
            end else if (s.tenths[i] >= (i == F_LOSS ? s.loss_detect_time[7:0] :
                         i == F_OVER ? s.overspeed_delay[7:0] :
                         s.deviation_delay[7:0])) begin
                det[i] = 1'b1;
            end else if (s.sub[i] == 24'(TENTH_CYC - 1)) begin
                n.sub[i]    = '0;
                n.tenths[i] = s.tenths[i] + 8'h1;
            end else begin
                n.sub[i] = s.sub[i] + 24'h1;
            end
        end

        // register writes, values beyond range are clamped
        if (reg_wr) begin
            unique case (reg_addr)
                REG_PULSES_PER_REV: n.pulses_per_rev = clampv(reg_wdata, PPR_MAX);
                REG_CONFIG: begin
                    n.cfg    = reg_wdata & CFG_MASK;
                    new_meth = reg_wdata[CFG_METHOD +: 2];
                    if (!s.delay_written && new_meth != s.cfg[CFG_METHOD +: 2]) begin
                        n.overspeed_delay = (new_meth == METHOD_FLUX) ?
                                            OVER_DLY_FLUX : OVER_DLY_VF;
                    end
                end
                REG_MONITOR_DIV: n.monitor_divider = clampv(reg_wdata, MON_MAX);
                REG_OVER_LEVEL: n.overspeed_level = clampv(reg_wdata, OVER_LVL_MAX);
                REG_OVER_DELAY: begin
                    n.overspeed_delay = clampv(reg_wdata, OVER_DLY_MAX);
                    n.delay_written   = 1'b1;
                end
                REG_DVTN_LEVEL: n.deviation_level = clampv(reg_wdata, DVTN_LVL_MAX);
                REG_DVTN_DELAY: n.deviation_delay = clampv(reg_wdata, DVTN_DLY_MAX);
                REG_GEAR_ONE: n.gear_teeth_one = clampv(reg_wdata, GEAR_MAX);
                REG_GEAR_TWO: n.gear_teeth_two = clampv(reg_wdata, GEAR_MAX);
                REG_LOSS_TIME: n.loss_detect_time = clampv(reg_wdata, LOSS_MAX);
                REG_MAX_RPM: n.max_output_frequency = reg_wdata;
                REG_EMERG_DECEL: n.emergency_decel_time = reg_wdata;
                REG_STATUS: clr = reg_wdata[2:0];
                default: ;
            endcase
        end
        // a new detection beats a clear in the same cycle
        n.hit = (s.hit & ~clr) | det;

        // read data only in the cycle after the strobe
        n.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_PULSES_PER_REV: n.rdata = s.pulses_per_rev;
                REG_CONFIG: n.rdata = s.cfg;
                REG_MONITOR_DIV: n.rdata = s.monitor_divider;
                REG_OVER_LEVEL: n.rdata = s.overspeed_level;
                REG_OVER_DELAY: n.rdata = s.overspeed_delay;
                REG_DVTN_LEVEL: n.rdata = s.deviation_level;
                REG_DVTN_DELAY: n.rdata = s.deviation_delay;
                REG_GEAR_ONE: n.rdata = s.gear_teeth_one;
                REG_GEAR_TWO: n.rdata = s.gear_teeth_two;
                REG_LOSS_TIME: n.rdata = s.loss_detect_time;
                REG_MAX_RPM: n.rdata = s.max_output_frequency;
                REG_EMERG_DECEL: n.rdata = s.emergency_decel_time;
                REG_SPEED: n.rdata = s.speed;
                REG_STATUS: n.rdata = {10'h0, act, s.hit};
                default: n.rdata = '0;
            endcase
        end

        // reactions: coast beats fast stop beats ramp stop
        react[F_LOSS] = s.cfg[CFG_LOSS +: 2];
        react[F_OVER] = s.cfg[CFG_OVER +: 2];
        react[F_DVTN] = s.cfg[CFG_DVTN +: 2];
        coast_any = 1'b0;
        fast_any  = 1'b0;
        ramp_any  = 1'b0;
        for (int i = 0; i < 3; i++) begin
            flt[i]    = s.hit[i] && react[i] != REACT_ALARM;
            coast_any = coast_any | (flt[i] && react[i] == REACT_COAST);
            fast_any  = fast_any | (flt[i] && react[i] == REACT_FAST);
            ramp_any  = ramp_any | (flt[i] && react[i] == REACT_RAMP);
        end
        n.decel = (fast_any && !coast_any) ? s.emergency_decel_time
                                           : active_decel_time;

        if (!rstn) begin
            n                      = '0;
            n.pulses_per_rev       = PPR_RST;
            n.cfg                  = CFG_RST;
            n.monitor_divider      = MON_RST;
            n.overspeed_level      = OVER_LVL_RST;
            n.overspeed_delay      = OVER_DLY_VF;
            n.deviation_level      = DVTN_LVL_RST;
            n.deviation_delay      = DVTN_DLY_RST;
            n.loss_detect_time     = LOSS_RST;
            n.max_output_frequency = MAX_RPM_RST;
            n.emergency_decel_time = EDECEL_RST;
            n.st                   = ST_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        s <= n;
    end

    // ==============================================
    // outputs
    assign reg_rdata     = s.rdata;
    assign speed_rpm     = s.speed;
    assign speed_valid   = s.spd_valid;
    assign pulse_monitor = s.mon_out;
    assign decel_time    = s.decel;
    assign integ_enable  = s.cfg[CFG_INTEG] || !ramping;
    assign fault_out     = |flt;
    assign alarm_out     = |(s.hit & ~flt);
    assign stop_coast    = coast_any;
    assign stop_fast     = fast_any && !coast_any;
    assign stop_ramp     = ramp_any && !coast_any && !fast_any;

    // ==============================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence window_closes;
        win_end && s.st == ST_IDLE && s.pulses_per_rev != 16'h0;
    endsequence
    sequence speed_lands;
        ##[49:50] speed_valid;
    endsequence

    a_ppr_range: assert property (s.pulses_per_rev <= PPR_MAX)
        else $error("pulses per rev out of range");
    a_loss_faults: assert property (s.hit[F_LOSS] && react[F_LOSS] != REACT_ALARM
        |-> fault_out)
        else $error("loss fault not raised");
    a_over_coast: assert property (s.hit[F_OVER] && react[F_OVER] == REACT_COAST
        |-> stop_coast && !stop_ramp)
        else $error("overspeed coast missing");
    a_dvtn_alarm_only: assert property (s.hit[F_DVTN] && react[F_DVTN] == REACT_ALARM
        && !flt[F_LOSS] && !flt[F_OVER] |-> alarm_out && !fault_out)
        else $error("alarm only stopped the drive");
    a_fast_decel: assert property (stop_fast |=> decel_time == $past(s.emergency_decel_time))
        else $error("fast stop decel time wrong");
    a_monitor_ratio: assert property (mon_m >= 6'(mon_n) + 6'h1 && mon_m <= 6'h20)
        else $error("monitor ratio out of range");
    a_integ_hold: assert property (ramping && !s.cfg[CFG_INTEG] |-> !integ_enable)
        else $error("integration not held");
    a_dvtn_inhibit: assert property (ramping || torque_mode
        |=> s.sub[F_DVTN] == 24'h0 && s.tenths[F_DVTN] == 8'h0)
        else $error("deviation timed while inhibited");
    a_over_cause: assert property ($rose(s.hit[F_OVER]) |-> $past(over_cond))
        else $error("overspeed without cause");
    a_speed_sample: assert property (window_closes |-> speed_lands)
        else $error("speed not updated after window");
endmodule : encoder_speed_supervisor
`default_nettype wire

// ---- ess_pkg.sv ----
`default_nettype none
package ess_pkg;
    // ==============================================
    // register map
    localparam int          DW                 = 16;
    localparam int          AW                 = 4;
    localparam logic [3:0]  REG_PULSES_PER_REV = 4'h0;
    localparam logic [3:0]  REG_CONFIG         = 4'h1;
    localparam logic [3:0]  REG_MONITOR_DIV    = 4'h2;
    localparam logic [3:0]  REG_OVER_LEVEL     = 4'h3;
    localparam logic [3:0]  REG_OVER_DELAY     = 4'h4;
    localparam logic [3:0]  REG_DVTN_LEVEL     = 4'h5;
    localparam logic [3:0]  REG_DVTN_DELAY     = 4'h6;
    localparam logic [3:0]  REG_GEAR_ONE       = 4'h7;
    localparam logic [3:0]  REG_GEAR_TWO       = 4'h8;
    localparam logic [3:0]  REG_LOSS_TIME      = 4'h9;
    localparam logic [3:0]  REG_MAX_RPM        = 4'ha;
    localparam logic [3:0]  REG_EMERG_DECEL    = 4'hb;
    localparam logic [3:0]  REG_SPEED          = 4'hc;
    localparam logic [3:0]  REG_STATUS         = 4'hd;
    // ==============================================
    // config fields
    localparam int          CFG_LOSS           = 0;
    localparam int          CFG_OVER           = 2;
    localparam int          CFG_DVTN           = 4;
    localparam int          CFG_DIR            = 6;
    localparam int          CFG_INTEG          = 7;
    localparam int          CFG_METHOD         = 8;
    localparam logic [15:0] CFG_MASK           = 16'h03ff;
    localparam logic [15:0] CFG_RST            = 16'h0135;
    localparam logic [1:0]  REACT_RAMP         = 2'h0;
    localparam logic [1:0]  REACT_COAST        = 2'h1;
    localparam logic [1:0]  REACT_FAST         = 2'h2;
    localparam logic [1:0]  REACT_ALARM        = 2'h3;
    localparam logic [1:0]  METHOD_FLUX        = 2'h3;
    // ==============================================
    // limits and reset values, delays in tenths of a second
    localparam logic [15:0] PPR_MAX            = 16'hea60;
    localparam logic [15:0] PPR_RST            = 16'h0400;
    localparam logic [15:0] MON_MAX            = 16'h0084;
    localparam logic [15:0] MON_RST            = 16'h0001;
    localparam logic [15:0] MON_N_STEP         = 16'h0064;
    localparam logic [15:0] MON_M_MAX          = 16'h0020;
    localparam logic [15:0] OVER_LVL_MAX       = 16'h0078;
    localparam logic [15:0] OVER_LVL_RST       = 16'h0073;
    localparam logic [15:0] OVER_DLY_MAX       = 16'h0014;
    localparam logic [15:0] OVER_DLY_VF        = 16'h000a;
    localparam logic [15:0] OVER_DLY_FLUX      = 16'h0000;
    localparam logic [15:0] DVTN_LVL_MAX       = 16'h0032;
    localparam logic [15:0] DVTN_LVL_RST       = 16'h000a;
    localparam logic [15:0] DVTN_DLY_MAX       = 16'h0064;
    localparam logic [15:0] DVTN_DLY_RST       = 16'h0005;
    localparam logic [15:0] GEAR_MAX           = 16'h03e8;
    localparam logic [15:0] LOSS_MAX           = 16'h0064;
    localparam logic [15:0] LOSS_RST           = 16'h0014;
    localparam int          F_LOSS             = 0;
    localparam int          F_OVER             = 1;
    localparam int          F_DVTN             = 2;
    // ==============================================
    // timing
    localparam longint      CLK_NS             = 10;
    localparam longint      SEC_NS             = 1000000000;
    localparam longint      TENTH_NS           = 100000000;
    localparam longint      TENTH_CYCLES       = TENTH_NS / CLK_NS;
    localparam longint      WINDOW_NS          = 1000000;
    localparam longint      WINDOW_CYCLES      = WINDOW_NS / CLK_NS;
    localparam longint      SEC_PER_MIN        = 60;
    localparam longint      EDGES_PER_PULSE    = 4;
    localparam int          PCT                = 100;
    localparam int          DIV_STEPS          = 48;
    typedef enum logic { ST_IDLE, ST_DIV } div_e;
endpackage : ess_pkg
`default_nettype wire

// ---- quad_encoder.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==============================================
// shaft encoder: one quadrature edge every HALF cycles while spinning
module quad_encoder #(
    parameter int HALF = 25
) (
    input  wire logic mclk,
    input  wire logic spin,
    input  wire logic b_lead,
    output logic      enc_a,
    output logic      enc_b
);
    int         cnt = 0;
    logic [1:0] ph  = 2'h0;
    // a stopped shaft really holds both levels, so no fake idle pattern
    always_ff @(posedge mclk) begin
        if (spin) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) ph <= ph + 2'h1;
        end
    end
    assign enc_a = b_lead ? ph[1] : ph[1] ^ ph[0];
    assign enc_b = b_lead ? ph[1] ^ ph[0] : ph[1];
endmodule : quad_encoder
`default_nettype wire

// ---- tb_encoder_speed_supervisor.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_encoder_speed_supervisor;
    import ess_pkg::*;
    typedef struct packed {logic [15:0] cfg, g1, g2; logic bl; logic [15:0] ex;} row_s;
    logic mclk = 0, rstn = 0, run_cmd = 0, ramping = 1, torque_mode = 0, reg_wr = 0, reg_rd = 0;
    logic spin = 0, b_lead = 0, enc_a, enc_b, speed_valid, pulse_monitor, integ_enable;
    logic fault_out, alarm_out, stop_ramp, stop_coast, stop_fast;
    logic signed [15:0] speed_ref = '0, speed_rpm;
    logic [15:0] active_decel_time = 16'h0032, reg_wdata = '0, reg_rdata, decel_time, v;
    logic [3:0]  reg_addr = '0;
    int          err_count = 0, total_checks = 0, mon_gap = 0;
    logic [19:0] rv[9] = '{20'h00400, 20'h10135, 20'h30073, 20'h4000a, 20'h5000a,
                           20'h60005, 20'h90014, 20'he0000, 20'hc0000};
    logic [4:0]  ex[4] = '{5'h14, 5'h12, 5'h11, 5'h08};
    // 10 edges land in every 250-cycle window, so 1000 rpm at 60000 ppr
    row_s rows[6] = '{'{16'h0135, 16'h0, 16'h0, 1'b0, 16'h03e8},
                      '{16'h0135, 16'h0, 16'h0, 1'b1, 16'hfc18},
                      '{16'h0175, 16'h0, 16'h0, 1'b1, 16'h03e8},
                      '{16'h0135, 16'h2, 16'h1, 1'b0, 16'h01f4},
                      '{16'h0335, 16'h2, 16'h1, 1'b0, 16'h03e8},
                      '{16'h0135, 16'h0, 16'h5, 1'b0, 16'h03e8}};
    encoder_speed_supervisor #(.TENTH_CYC(20), .WIN_CYC(250)) u_dut (.*);
    quad_encoder u_enc (.*);
    initial forever #5 mclk = ~mclk;
    // ==============================================
    // shared tasks
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk) reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask : rd
    // skips windows that may straddle a configuration change
    task automatic wait_valid;
        int n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (speed_valid !== 1'b1 && n < 400);
        chk("speed_valid", {15'h0, speed_valid}, 16'h1);
        @(posedge mclk);
    endtask : wait_valid
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        close_out();
    end
    // ==============================================
    // main sequence
    initial begin
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        foreach (rv[i]) begin
            rd(rv[i][19:16], v);
            chk("reset value", v, rv[i][15:0]);
        end
        chk("integ_enable", {15'h0, integ_enable}, 16'h0);
        wr(REG_PULSES_PER_REV, 16'hffff);
        rd(REG_PULSES_PER_REV, v);
        chk("ppr clamp", v, 16'hea60);
        spin <= 1'b1;
        foreach (rows[i]) begin
            wr(REG_CONFIG, rows[i].cfg);
            wr(REG_GEAR_ONE, rows[i].g1);
            wr(REG_GEAR_TWO, rows[i].g2);
            b_lead <= rows[i].bl;
            repeat (3) wait_valid();
            chk("speed_rpm", speed_rpm, rows[i].ex);
        end
        // ratio 2/16: a toggle every 8 A edges, 50 cycles apart
        wr(REG_MONITOR_DIV, 16'h0074);
        repeat (2) @(pulse_monitor);
        v[0]    = pulse_monitor;
        mon_gap = 0;
        do begin
            @(posedge mclk);
            #1 mon_gap++;
        end while (pulse_monitor == v[0] && mon_gap < 500);
        chk("monitor period", 16'(mon_gap), 16'h0190);
        @(posedge mclk);
        wr(REG_MAX_RPM, 16'h0320);
        repeat (150) @(posedge mclk);
        #1 chk("early overspeed", {15'h0, fault_out}, 16'h0);
        repeat (110) @(posedge mclk);
        for (int c = 0; c < 4; c++) begin
            wr(REG_CONFIG, 16'h0131 | 16'(c << 2));
            #1 chk("reaction", {11'h0, fault_out, alarm_out, stop_ramp, stop_coast, stop_fast},
                   {11'h0, ex[c]});
            chk("decel_time", decel_time, (c == 2) ? 16'h0064 : 16'h0032);
            @(posedge mclk);
        end
        repeat (200) @(posedge mclk);
        rd(REG_STATUS, v);
        chk("deviation while ramping", v & 16'h0004, 16'h0);
        ramping     <= 1'b0;
        torque_mode <= 1'b1;
        repeat (200) @(posedge mclk);
        rd(REG_STATUS, v);
        chk("deviation in torque mode", v & 16'h0004, 16'h0);
        torque_mode <= 1'b0;
        repeat (150) @(posedge mclk);
        rd(REG_STATUS, v);
        chk("deviation flag", v & 16'h0004, 16'h0004);
        chk("integ_enable", {15'h0, integ_enable}, 16'h1);
        spin    <= 1'b0;
        run_cmd <= 1'b1;
        wr(REG_STATUS, 16'h0007);
        repeat (300) @(posedge mclk);
        rd(REG_STATUS, v);
        chk("early loss", v & 16'h0001, 16'h0);
        repeat (150) @(posedge mclk);
        rd(REG_STATUS, v);
        chk("loss flag", v & 16'h0001, 16'h0001);
        // ==============================================
        // reset in mid-run drops settings and latched flags
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(REG_CONFIG, v);
        chk("config after reset", v, 16'h0135);
        rd(REG_STATUS, v);
        chk("flags after reset", v & 16'h0007, 16'h0);
        chk("fault after reset", {15'h0, fault_out}, 16'h0);
        close_out();
    end
endmodule : tb_encoder_speed_supervisor
`default_nettype wire
